// ---- hdl/ddr_link_pkg.sv ----
// Purpose: Shared constants, types and helpers for the DDR2 command link
// Assumes: 100 MHz system clock on both ends
// Notes: Small array model keeps only low row and column bits
package ddr_link_pkg;
   localparam int ADDR_W = 15;
   localparam int BA_W = 3;
   localparam int RANKS = 2;
   localparam int BANKS = 8;
   localparam int MODE_REGS = 4;
   localparam int MR_SEL_W = 2;
   localparam int DQ_W = 8;
   localparam int COL_KEEP = 2;
   localparam int MEM_IDX_W = 1 + BA_W + 1 + COL_KEEP;
   localparam int MEM_WORDS = 1 << MEM_IDX_W;
   localparam int AP_BIT = 10;
   localparam int EMR1_SEL = 1;
   localparam int RTT_BIT_LO = 2;
   localparam int RTT_BIT_HI = 6;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CK_PERIOD_NS = 160;
   localparam int CK_HALF = CK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int DIV_W = $clog2(CK_HALF);
   localparam int PD_EXIT_CK = 3;
   localparam int PX_W = 2;
   localparam int WFIFO_DEPTH = 8;
   localparam int WFIFO_W = 2 * DQ_W + 2;
   localparam logic [COL_KEEP-1:0] COL_STEP = 2'h1;
   localparam logic [1:0] RD_START = 2'h3;
   localparam logic [ADDR_W-1:0] MODE_RESET = 15'h0000;
   localparam logic [2:0] RCW_LOAD_MODE = 3'h0;
   localparam logic [2:0] RCW_REFRESH = 3'h1;
   localparam logic [2:0] RCW_PRECHARGE = 3'h2;
   localparam logic [2:0] RCW_ACTIVATE = 3'h3;
   localparam logic [2:0] RCW_WRITE = 3'h4;
   localparam logic [2:0] RCW_READ = 3'h5;
   localparam logic [2:0] RCW_NOP = 3'h7;

   typedef enum logic [2:0] {CMD_LOAD_MODE, CMD_REFRESH, CMD_PRECHARGE, CMD_ACTIVATE,
                             CMD_WRITE, CMD_READ, CMD_NOP} cmd_e;
   typedef enum logic [1:0] {PWR_ON, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF} pwr_e;

   function automatic cmd_e cmd_decode(input logic [2:0] rcw);
      case (rcw)
         RCW_LOAD_MODE: cmd_decode = CMD_LOAD_MODE;
         RCW_REFRESH: cmd_decode = CMD_REFRESH;
         RCW_PRECHARGE: cmd_decode = CMD_PRECHARGE;
         RCW_ACTIVATE: cmd_decode = CMD_ACTIVATE;
         RCW_WRITE: cmd_decode = CMD_WRITE;
         RCW_READ: cmd_decode = CMD_READ;
         default: cmd_decode = CMD_NOP;
      endcase
   endfunction

   function automatic logic [2:0] cmd_encode(input cmd_e cmd);
      case (cmd)
         CMD_LOAD_MODE: cmd_encode = RCW_LOAD_MODE;
         CMD_REFRESH: cmd_encode = RCW_REFRESH;
         CMD_PRECHARGE: cmd_encode = RCW_PRECHARGE;
         CMD_ACTIVATE: cmd_encode = RCW_ACTIVATE;
         CMD_WRITE: cmd_encode = RCW_WRITE;
         CMD_READ: cmd_encode = RCW_READ;
         default: cmd_encode = RCW_NOP;
      endcase
   endfunction

   function automatic logic [MEM_IDX_W-1:0] mem_index(input logic rank,
      input logic [BA_W-1:0] ba, input logic row0, input logic [COL_KEEP-1:0] col);
      mem_index = {rank, ba, row0, col};
   endfunction
endpackage

// ---- hdl/ddr_link_if.sv ----
// Purpose: Pin bundle between memory controller and dual-rank DDR2 device
// Assumes: Controller drives all command pins and the link clock
// Notes: Shared data pins resolve here from both ends' enables
`timescale 1ns/1ns
`default_nettype none
interface ddr_link_if;
   import ddr_link_pkg::*;
   logic ck;
   logic ck_n;
   logic [RANKS-1:0] cke;
   logic [RANKS-1:0] cs_n;
   logic [RANKS-1:0] odt;
   logic [2:0] rcw;
   logic [BA_W-1:0] ba;
   logic [ADDR_W-1:0] addr;
   logic dm;
   logic [DQ_W-1:0] ctl_dq_o;
   logic ctl_dq_oe;
   logic ctl_dqs_o;
   logic ctl_dqs_oe;
   logic [DQ_W-1:0] mem_dq_o;
   logic mem_dq_oe;
   logic mem_dqs_o;
   logic mem_dqs_oe;
   wire logic [DQ_W-1:0] dq;
   wire logic dqs;

   // Undriven bus reads as zero
   assign dq = ctl_dq_oe ? ctl_dq_o : (mem_dq_oe ? mem_dq_o : '0);
   assign dqs = ctl_dqs_oe ? ctl_dqs_o : (mem_dqs_oe ? mem_dqs_o : 1'b0);

   modport ctl (output ck, ck_n, cke, cs_n, odt, rcw, ba, addr, dm,
                output ctl_dq_o, ctl_dq_oe, ctl_dqs_o, ctl_dqs_oe, input dq, dqs);
   modport mem (input ck, ck_n, cke, cs_n, odt, rcw, ba, addr, dm, dq, dqs,
                output mem_dq_o, mem_dq_oe, mem_dqs_o, mem_dqs_oe);
endinterface
`default_nettype wire

// ---- hdl/sync_fifo.sv ----
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock
// Notes: Flags are registered
`timescale 1ns/1ns
`default_nettype none
module sync_fifo #(
   parameter int WIDTH = ddr_link_pkg::WFIFO_W,
   parameter int DEPTH = ddr_link_pkg::WFIFO_DEPTH
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   import ddr_link_pkg::*;
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] slots [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [CW-1:0] count;

   function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
      next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   wire logic push = in_valid && in_ready;
   wire logic pop = out_valid && out_ready;
   wire logic [CW-1:0] next_count = count + CW'(push) - CW'(pop);
   assign out_data = slots[rd_ptr];

   always_ff @(posedge clk)
   begin
      if (push)
         slots[wr_ptr] <= in_data;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
      end
      else
      begin
         if (push)
            wr_ptr <= next_ptr(wr_ptr);
         if (pop)
            rd_ptr <= next_ptr(rd_ptr);
         count <= next_count;
         in_ready <= next_count != CW'(DEPTH);
         out_valid <= next_count != '0;
      end
   end
endmodule // sync_fifo
`default_nettype wire

// ---- hdl/ddr_rank_pair.sv ----
// Purpose: Command, address and control input side of a two-rank DDR2 memory
// Assumes: All pins arrive asynchronously and pass two flip-flops
// Notes: Tiny array keeps row bit 0 and column bits 1:0 only
`timescale 1ns/1ns
`default_nettype none
module ddr_rank_pair (
   input wire logic clk,
   input wire logic reset_n,
   ddr_link_if.mem link,
   output var ddr_link_pkg::pwr_e rank_power [ddr_link_pkg::RANKS],
   output logic [ddr_link_pkg::BANKS-1:0] open_banks [ddr_link_pkg::RANKS],
   output logic term_on [ddr_link_pkg::RANKS],
   output var ddr_link_pkg::cmd_e last_cmd,
   output logic cmd_taken
);
   import ddr_link_pkg::*;
   localparam int IN_W = 2 + 3 * RANKS + 3 + BA_W + ADDR_W + 2 + DQ_W;

   logic [IN_W-1:0] pin_meta;
   logic [IN_W-1:0] pin_sync;
   logic ck_prev;
   logic dqs_prev;
   wire logic ck_s;
   wire logic ckn_s;
   wire logic [RANKS-1:0] cke_s;
   wire logic [RANKS-1:0] cs_s;
   wire logic [RANKS-1:0] odt_s;
   wire logic [2:0] rcw_s;
   wire logic [BA_W-1:0] ba_s;
   wire logic [ADDR_W-1:0] addr_s;
   wire logic dm_s;
   wire logic dqs_s;
   wire logic [DQ_W-1:0] dq_s;
   wire logic [IN_W-1:0] pin_raw = {link.ck, link.ck_n, link.cke, link.cs_n, link.odt,
                                    link.rcw, link.ba, link.addr, link.dm, link.dqs, link.dq};
   assign {ck_s, ckn_s, cke_s, cs_s, odt_s, rcw_s, ba_s, addr_s, dm_s, dqs_s, dq_s} = pin_sync;

   wire logic ck_rise = ck_s && !ckn_s && !ck_prev;
   wire logic dqs_rise = dqs_s && !dqs_prev;
   wire logic dqs_fall = !dqs_s && dqs_prev;
   wire cmd_e cmd = cmd_decode(rcw_s);
   wire logic [RANKS-1:0] take;
   wire logic take_any = |take;
   wire logic take_rank = take[0] ? 1'b0 : 1'b1;
   wire logic is_access = cmd == CMD_READ || cmd == CMD_WRITE;

   logic [DQ_W-1:0] cells [MEM_WORDS];
   logic [ADDR_W-1:0] row_of [RANKS * BANKS];
   logic acc_rank;
   logic acc_row0;
   logic acc_ap;
   logic [BA_W-1:0] acc_ba;
   logic [COL_KEEP-1:0] acc_col;
   logic wr_pend;
   logic wr_beat;
   logic wr_done;
   logic rd_done;
   logic [2*DQ_W-1:0] rd_word;
   logic [1:0] rd_cnt;

   wire logic [BA_W:0] take_slot = {take_rank, ba_s};
   wire logic take_row0 = row_of[take_slot][0];
   wire logic [COL_KEEP-1:0] take_col = addr_s[COL_KEEP-1:0];
   wire logic [MEM_IDX_W-1:0] rd_idx0 = mem_index(take_rank, ba_s, take_row0, take_col);
   wire logic [MEM_IDX_W-1:0] rd_idx1 = mem_index(take_rank, ba_s, take_row0,
                                                  take_col ^ COL_STEP);
   wire logic [MEM_IDX_W-1:0] wr_idx = mem_index(acc_rank, acc_ba, acc_row0,
                                                 wr_beat ? acc_col ^ COL_STEP : acc_col);
   wire logic wr_edge = wr_pend && (wr_beat ? dqs_fall : dqs_rise);
   wire logic ap_close = (wr_done || rd_done) && acc_ap;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
         ck_prev <= 1'b0;
         dqs_prev <= 1'b0;
         cmd_taken <= 1'b0;
         last_cmd <= CMD_NOP;
      end
      else
      begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
         ck_prev <= ck_s;
         dqs_prev <= dqs_s;
         cmd_taken <= take_any;
         if (take_any)
            last_cmd <= cmd;
      end
   end

   // Array and row store
   always_ff @(posedge clk)
   begin
      if (wr_edge && !dm_s)
         cells[wr_idx] <= dq_s;
      if (take_any && cmd == CMD_ACTIVATE)
         row_of[take_slot] <= addr_s;
   end

   // Write burst capture on strobe edges
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         acc_rank <= 1'b0;
         acc_row0 <= 1'b0;
         acc_ap <= 1'b0;
         acc_ba <= '0;
         acc_col <= '0;
         wr_pend <= 1'b0;
         wr_beat <= 1'b0;
         wr_done <= 1'b0;
      end
      else
      begin
         wr_done <= 1'b0;
         if (take_any && is_access)
         begin
            acc_rank <= take_rank;
            acc_row0 <= take_row0;
            acc_ap <= addr_s[AP_BIT];
            acc_ba <= ba_s;
            acc_col <= take_col;
         end
         if (take_any && cmd == CMD_WRITE)
         begin
            wr_pend <= 1'b1;
            wr_beat <= 1'b0;
         end
         else if (wr_edge && wr_beat)
         begin
            wr_pend <= 1'b0;
            wr_done <= 1'b1;
         end
         else if (wr_edge)
            wr_beat <= 1'b1;
      end
   end

   // Read burst driven from clock crossings
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rd_word <= '0;
         rd_cnt <= 2'h0;
         rd_done <= 1'b0;
         link.mem_dq_o <= '0;
         link.mem_dq_oe <= 1'b0;
         link.mem_dqs_o <= 1'b0;
         link.mem_dqs_oe <= 1'b0;
      end
      else
      begin
         rd_done <= 1'b0;
         if (take_any && cmd == CMD_READ)
         begin
            rd_word <= {cells[rd_idx1], cells[rd_idx0]};
            rd_cnt <= RD_START;
         end
         else if (ck_rise && rd_cnt != 2'h0)
         begin
            rd_cnt <= rd_cnt - 2'h1;
            rd_done <= rd_cnt == 2'h1;
            link.mem_dq_oe <= rd_cnt != 2'h1;
            link.mem_dqs_oe <= rd_cnt != 2'h1;
            link.mem_dqs_o <= rd_cnt == RD_START;
            link.mem_dq_o <= (rd_cnt == RD_START) ? rd_word[DQ_W-1:0] : rd_word[2*DQ_W-1:DQ_W];
         end
      end
   end

   // Independent rank state
   for (genvar r = 0; r < RANKS; r++)
   begin : g_rank
      logic [ADDR_W-1:0] mode_reg [MODE_REGS];
      logic cke_reg;
      wire logic rtt_on = mode_reg[EMR1_SEL][RTT_BIT_LO] || mode_reg[EMR1_SEL][RTT_BIT_HI];
      wire logic cke_fell = ck_rise && cke_reg && !cke_s[r];
      wire logic enter_sr = !cs_s[r] && cmd == CMD_REFRESH;
      // Decoder live only with rank clocked and selected
      assign take[r] = ck_rise && !cs_s[r] && cke_s[r] && rank_power[r] == PWR_ON;

      always_ff @(posedge clk or negedge reset_n)
      begin
         if (!reset_n)
         begin
            cke_reg <= 1'b0;
            rank_power[r] <= PWR_PRE_PD;
            open_banks[r] <= '0;
            term_on[r] <= 1'b0;
            for (int m = 0; m < MODE_REGS; m++)
               mode_reg[m] <= MODE_RESET;
         end
         else
         begin
            if (ck_rise || rank_power[r] == PWR_SELF_REF)
               cke_reg <= cke_s[r];
            case (rank_power[r])
               PWR_ON:
                  if (cke_fell)
                     rank_power[r] <= enter_sr ? PWR_SELF_REF :
                        (|open_banks[r] ? PWR_ACT_PD : PWR_PRE_PD);
               PWR_PRE_PD, PWR_ACT_PD:
                  if (ck_rise && cke_s[r])
                     rank_power[r] <= PWR_ON;
               default:
                  if (cke_s[r])
                     rank_power[r] <= PWR_ON;
            endcase
            if (ck_rise)
               term_on[r] <= odt_s[r] && rtt_on && rank_power[r] != PWR_SELF_REF;
            if (take[r] && cmd == CMD_ACTIVATE)
               open_banks[r][ba_s] <= 1'b1;
            if (take[r] && cmd == CMD_PRECHARGE && addr_s[AP_BIT])
               open_banks[r] <= '0;
            else if (take[r] && cmd == CMD_PRECHARGE)
               open_banks[r][ba_s] <= 1'b0;
            if (take[r] && cmd == CMD_LOAD_MODE)
               mode_reg[ba_s[MR_SEL_W-1:0]] <= addr_s;
            if (ap_close && acc_rank == 1'(r))
               open_banks[r][acc_ba] <= 1'b0;
         end
      end
   end
endmodule // ddr_rank_pair
`default_nettype wire

// ---- hdl/ddr_cmd_master.sv ----
// Purpose: Memory controller end that issues commands and write bursts
// Assumes: Device answers reads within one burst
// Notes: One command at a time; write data from an 8-word FIFO
`timescale 1ns/1ns
`default_nettype none
module ddr_cmd_master (
   input wire logic clk,
   input wire logic reset_n,
   ddr_link_if.ctl link,
   input wire logic req_valid,
   output logic req_ready,
   input wire ddr_link_pkg::cmd_e req_cmd,
   input wire logic req_rank,
   input wire logic [ddr_link_pkg::BA_W-1:0] req_ba,
   input wire logic [ddr_link_pkg::ADDR_W-1:0] req_addr,
   output logic req_err,
   input wire logic [ddr_link_pkg::RANKS-1:0] cke_want,
   input wire logic [ddr_link_pkg::RANKS-1:0] odt_want,
   output logic [ddr_link_pkg::RANKS-1:0] rank_ready,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [ddr_link_pkg::WFIFO_W-1:0] wr_data,
   output logic rd_valid,
   output logic [2*ddr_link_pkg::DQ_W-1:0] rd_data
);
   import ddr_link_pkg::*;
   typedef enum logic [2:0] {S_IDLE, S_CMD, S_W_PRE, S_W_B0, S_W_B1, S_W_END, S_RD} state_e;

   state_e state;
   cmd_e cur_cmd;
   logic [DIV_W-1:0] div_cnt;
   logic [PX_W-1:0] exit_cnt [RANKS];
   logic [WFIFO_W-1:0] wbuf;
   logic [DQ_W:0] rx_meta;
   logic [DQ_W:0] rx_sync;
   logic dqs_prev;
   wire logic f_valid;
   wire logic [WFIFO_W-1:0] f_data;

   wire logic div_end = div_cnt == DIV_W'(CK_HALF - 1);
   wire logic fall_evt = div_end && link.ck;
   wire logic rise_evt = div_end && !link.ck;
   wire logic fall_soon = div_cnt == DIV_W'(CK_HALF - 2) && link.ck;
   wire logic take = req_valid && req_ready;
   wire logic allowed = rank_ready[req_rank] && (req_cmd != CMD_WRITE || f_valid);
   wire logic take_ok = take && allowed;
   wire logic pop = take_ok && req_cmd == CMD_WRITE;
   wire logic dqs_s = rx_sync[DQ_W];
   wire logic rd_rise = state == S_RD && dqs_s && !dqs_prev;
   wire logic rd_fall = state == S_RD && !dqs_s && dqs_prev;

   sync_fifo #(.WIDTH(WFIFO_W), .DEPTH(WFIFO_DEPTH)) u_wfifo (
      .clk(clk),
      .reset_n(reset_n),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .in_data(wr_data),
      .out_valid(f_valid),
      .out_ready(pop),
      .out_data(f_data)
   );

   // Link clock divider and rank wake-up
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         div_cnt <= '0;
         link.ck <= 1'b0;
         link.ck_n <= 1'b1;
         link.cke <= '0;
         link.odt <= '0;
         rank_ready <= '0;
         for (int r = 0; r < RANKS; r++)
            exit_cnt[r] <= '0;
      end
      else
      begin
         div_cnt <= div_end ? '0 : div_cnt + 1'b1;
         if (div_end)
         begin
            link.ck <= !link.ck;
            link.ck_n <= link.ck;
         end
         if (fall_evt)
         begin
            link.cke <= cke_want;
            link.odt <= odt_want;
         end
         for (int r = 0; r < RANKS; r++)
         begin
            if (rise_evt && !link.cke[r])
               exit_cnt[r] <= '0;
            else if (rise_evt && exit_cnt[r] != PX_W'(PD_EXIT_CK))
               exit_cnt[r] <= exit_cnt[r] + 1'b1;
            rank_ready[r] <= link.cke[r] && exit_cnt[r] == PX_W'(PD_EXIT_CK);
         end
      end
   end

   // Command and write-burst sequencer
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= S_IDLE;
         cur_cmd <= CMD_NOP;
         wbuf <= '0;
         req_ready <= 1'b0;
         req_err <= 1'b0;
         link.cs_n <= '1;
         link.rcw <= RCW_NOP;
         link.ba <= '0;
         link.addr <= '0;
         link.dm <= 1'b0;
         link.ctl_dq_o <= '0;
         link.ctl_dq_oe <= 1'b0;
         link.ctl_dqs_o <= 1'b0;
         link.ctl_dqs_oe <= 1'b0;
      end
      else
      begin
         req_ready <= fall_soon && state == S_IDLE;
         req_err <= take && !allowed;
         case (state)
            S_IDLE:
               if (take_ok)
               begin
                  state <= S_CMD;
                  cur_cmd <= req_cmd;
                  wbuf <= f_data;
                  link.cs_n <= ~(RANKS'(1) << req_rank);
                  link.rcw <= cmd_encode(req_cmd);
                  link.ba <= req_ba;
                  link.addr <= req_addr;
               end
            S_CMD:
               if (fall_evt)
               begin
                  link.cs_n <= '1;
                  link.rcw <= RCW_NOP;
                  state <= cur_cmd == CMD_WRITE ? S_W_PRE : (cur_cmd == CMD_READ ? S_RD : S_IDLE);
                  link.ctl_dq_oe <= cur_cmd == CMD_WRITE;
                  link.ctl_dqs_oe <= cur_cmd == CMD_WRITE;
                  link.ctl_dqs_o <= 1'b0;
                  link.ctl_dq_o <= wbuf[DQ_W-1:0];
                  link.dm <= wbuf[2*DQ_W];
               end
            S_W_PRE:
               if (fall_evt)
               begin
                  link.ctl_dqs_o <= 1'b1;
                  state <= S_W_B0;
               end
            S_W_B0:
               if (rise_evt)
               begin
                  link.ctl_dq_o <= wbuf[2*DQ_W-1:DQ_W];
                  link.dm <= wbuf[2*DQ_W+1];
                  state <= S_W_B1;
               end
            S_W_B1:
               if (fall_evt)
               begin
                  link.ctl_dqs_o <= 1'b0;
                  state <= S_W_END;
               end
            S_W_END:
               if (rise_evt)
               begin
                  link.ctl_dq_oe <= 1'b0;
                  link.ctl_dqs_oe <= 1'b0;
                  link.dm <= 1'b0;
                  state <= S_IDLE;
               end
            default:
               if (rd_fall)
                  state <= S_IDLE;
         endcase
      end
   end

   // Read capture on device strobe
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rx_meta <= '0;
         rx_sync <= '0;
         dqs_prev <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= '0;
      end
      else
      begin
         rx_meta <= {link.dqs, link.dq};
         rx_sync <= rx_meta;
         dqs_prev <= dqs_s;
         rd_valid <= rd_fall;
         if (rd_rise)
            rd_data[DQ_W-1:0] <= rx_sync[DQ_W-1:0];
         if (rd_fall)
            rd_data[2*DQ_W-1:DQ_W] <= rx_sync[DQ_W-1:0];
      end
   end
endmodule // ddr_cmd_master
`default_nettype wire

// ---- sim/ddr2_dual_rank_cmd_input_properties.sv ----
// Purpose: Pin checks on the command link
// Assumes: Both ends run on clk
// Notes: Inputs mirror interface signals
`timescale 1ns/1ns
`default_nettype none
module ddr2_dual_rank_cmd_input_properties (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ck,
   input wire logic ck_n,
   input wire logic [1:0] cke,
   input wire logic [1:0] cs_n,
   input wire logic [2:0] rcw,
   input wire logic [2:0] ba,
   input wire logic [14:0] addr,
   input wire logic dm,
   input wire logic ctl_dq_oe,
   input wire logic mem_dq_oe
);
   import ddr_link_pkg::*;
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   property p_diff; ck_n == ~ck; endproperty
   a_diff: assert property (p_diff) else $error("ck_n not inverse");
   property p_hold; $rose(ck) |-> $stable({cs_n, rcw, ba, addr}); endproperty
   a_hold: assert property (p_hold) else $error("pins move at ck rise");
   property p_one; cs_n != 2'b00; endproperty
   a_one: assert property (p_one) else $error("both ranks selected");
   property p_cke; (~cs_n & ~cke) == 2'b00; endproperty
   a_cke: assert property (p_cke) else $error("rank selected, cke low");
   property p_idle; &cs_n |-> rcw == RCW_NOP; endproperty
   a_idle: assert property (p_idle) else $error("idle without nop");
   property p_bus; !(ctl_dq_oe && mem_dq_oe); endproperty
   a_bus: assert property (p_bus) else $error("bus driven twice");
   property p_wr; $rose(ctl_dq_oe) |-> $past(rcw) == RCW_WRITE; endproperty
   a_wr: assert property (p_wr) else $error("data without write");
   property p_dm; dm |-> ctl_dq_oe; endproperty
   a_dm: assert property (p_dm) else $error("mask outside burst");
   c_wr: cover property ($rose(ctl_dq_oe));
   c_rd: cover property ($rose(mem_dq_oe));
   c_ld: cover property (rcw == RCW_LOAD_MODE && !cs_n[0]);
endmodule // ddr2_dual_rank_cmd_input_properties
`default_nettype wire

// ---- sim/ddr2_dual_rank_cmd_input_tb.sv ----
// Purpose: Runs controller and device ends across the link
// Assumes: 100 MHz clk
// Notes: Each scenario judges its own results
`timescale 1ns/1ns
`default_nettype none
module ddr2_dual_rank_cmd_input_tb;
   import ddr_link_pkg::*;
   logic clk, reset_n, req_valid, req_rank, req_ready, req_err, wr_valid, wr_ready, rd_valid;
   logic cmd_taken;
   cmd_e req_cmd, last_cmd;
   logic [2:0] req_ba;
   logic [14:0] req_addr;
   logic [1:0] cke_want, odt_want, rank_ready;
   logic [17:0] wr_data;
   logic [15:0] rd_data;
   pwr_e rank_power [RANKS];
   logic [7:0] open_banks [RANKS];
   logic term_on [RANKS];
   int bad_count, checked;
   ddr_link_if link ();
   ddr_cmd_master i_ddr_cmd_master (.clk(clk), .reset_n(reset_n), .link(link),
      .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd), .req_rank(req_rank),
      .req_ba(req_ba), .req_addr(req_addr), .req_err(req_err), .cke_want(cke_want),
      .odt_want(odt_want), .rank_ready(rank_ready), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data));
   ddr_rank_pair i_ddr_rank_pair (.clk(clk), .reset_n(reset_n), .link(link),
      .rank_power(rank_power), .open_banks(open_banks), .term_on(term_on),
      .last_cmd(last_cmd), .cmd_taken(cmd_taken));
   ddr2_dual_rank_cmd_input_properties i_props (.clk(clk), .reset_n(reset_n), .ck(link.ck),
      .ck_n(link.ck_n), .cke(link.cke), .cs_n(link.cs_n), .rcw(link.rcw), .ba(link.ba),
      .addr(link.addr), .dm(link.dm), .ctl_dq_oe(link.ctl_dq_oe), .mem_dq_oe(link.mem_dq_oe));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic req(input cmd_e c, input logic r, input logic [2:0] b, input logic [14:0] a,
      input logic err);
      logic seen_err;
      int n;
      @(negedge clk);
      req_cmd = c;
      {req_rank, req_ba, req_addr, req_valid} = {r, b, a, 1'b1};
      n = 0;
      while (req_ready !== 1'b1 && n++ < 300)
         @(negedge clk);
      check("ready_wait", n > 300, 1'b0);
      @(negedge clk);
      req_valid = 0;
      seen_err = req_err;
      repeat (3)
      begin
         @(negedge clk);
         seen_err = seen_err | req_err;
      end
      check("req_err", seen_err, err);
      n = 0;
      while (!err && cmd_taken !== 1'b1 && n++ < 300)
         @(negedge clk);
      check("take_wait", n > 300, 1'b0);
      repeat (2) @(negedge clk);
   endtask
   task automatic push(input logic [17:0] w);
      @(negedge clk);
      {wr_data, wr_valid} = {w, 1'b1};
      while (wr_ready !== 1'b1)
         @(negedge clk);
      @(negedge clk);
      wr_valid = 0;
   endtask
   task automatic t_refuse();
      req(CMD_ACTIVATE, 1'b0, 3'h0, 15'h0000, 1'b1);
      cke_want = 2'b01;
      while (rank_ready[0] !== 1'b1)
         @(negedge clk);
      req(CMD_ACTIVATE, 1'b1, 3'h0, 15'h0000, 1'b1);
      req(CMD_WRITE, 1'b0, 3'h0, 15'h0000, 1'b1);
   endtask
   task automatic t_banks();
      req(CMD_ACTIVATE, 1'b0, 3'h5, 15'h0001, 1'b0);
      check("open0", open_banks[0], 8'h20);
      check("open1", open_banks[1], 8'h00);
      check("last", last_cmd, CMD_ACTIVATE);
      req(CMD_ACTIVATE, 1'b0, 3'h2, 15'h0000, 1'b0);
      req(CMD_PRECHARGE, 1'b0, 3'h5, 15'h0000, 1'b0);
      check("one", open_banks[0], 8'h04);
      req(CMD_ACTIVATE, 1'b0, 3'h5, 15'h0000, 1'b0);
      req(CMD_PRECHARGE, 1'b0, 3'h0, 15'h0400, 1'b0);
      check("all", open_banks[0], 8'h00);
   endtask
   task automatic t_mode();
      odt_want = 2'b01;
      repeat (40) @(negedge clk);
      check("term_off", term_on[0], 1'b0);
      req(CMD_LOAD_MODE, 1'b0, 3'h1, 15'h0004, 1'b0);
      repeat (40) @(negedge clk);
      check("term", term_on[0], 1'b1);
   endtask
   task automatic t_data();
      int n;
      req(CMD_ACTIVATE, 1'b0, 3'h3, 15'h0000, 1'b0);
      push({2'b00, 8'haa, 8'h55});
      push({2'b10, 8'hcc, 8'h33});
      req(CMD_WRITE, 1'b0, 3'h3, 15'h0001, 1'b0);
      req(CMD_WRITE, 1'b0, 3'h3, 15'h0001, 1'b0);
      req(CMD_READ, 1'b0, 3'h3, 15'h0401, 1'b0);
      n = 0;
      while (rd_valid !== 1'b1 && n++ < 300)
         @(negedge clk);
      check("rd_wait", n > 300, 1'b0);
      check("rd", rd_data, 16'haa33);
      repeat (40) @(negedge clk);
      check("ap", open_banks[0], 8'h00);
   endtask
   task automatic t_power();
      req(CMD_ACTIVATE, 1'b0, 3'h1, 15'h0000, 1'b0);
      cke_want = 2'b00;
      repeat (60) @(negedge clk);
      check("act_pd", rank_power[0], PWR_ACT_PD);
      cke_want = 2'b01;
      while (rank_ready[0] !== 1'b1)
         @(negedge clk);
      check("on", rank_power[0], PWR_ON);
      req(CMD_PRECHARGE, 1'b0, 3'h0, 15'h0400, 1'b0);
      cke_want = 2'b00;
      repeat (60) @(negedge clk);
      check("pre_pd", rank_power[0], PWR_PRE_PD);
      check("pwr1", rank_power[1], PWR_PRE_PD);
   endtask
   initial
   begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      #300000;
      bad_count++;
      conclude();
   end
   initial
   begin
      {reset_n, req_valid, req_rank, req_ba, req_addr, wr_valid, wr_data} = '0;
      {cke_want, odt_want} = '0;
      req_cmd = CMD_NOP;
      repeat (4) @(negedge clk);
      reset_n = 1;
      t_refuse();
      t_banks();
      t_mode();
      t_data();
      t_power();
      conclude();
   end
endmodule // ddr2_dual_rank_cmd_input_tb
`default_nettype wire
